// ==== hdl/pls_top.sv ====
/*
  Pin-level indicator drive and shared interrupt/transmit-error pin select.
  Assumes link, activity, speed and isolation flags come from core logic,
  all synchronous to core_clk; power-on reset arrives as sys_rst.
*/
`timescale 1ns/1ps
module pls_top #(
  parameter int unsigned BLINK_HALF_CYCLES = pls_pkg::BLINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic external_reset_n,
  input wire logic irq_pin_function_strap,
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  input wire logic line_isolate,
  input wire logic irq_request,
  input wire logic shared_pin_in,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_drive,
  input wire logic mdio_out_val,
  output logic link_activity_led,
  output logic speed_led,
  output logic interrupt_out_n,
  output logic shared_pin_oe,
  output logic transmit_error_in,
  output logic transmit_symbol_bit4,
  output logic mdc_core,
  output logic mdio_core_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic soft_reset_req
);
  // Elaboration-time refusal of a blink period the counter cannot serve
  if (BLINK_HALF_CYCLES < 1) begin : g_bad_blink
    $error("BLINK_HALF_CYCLES must be at least 1");
  end

  localparam int CW = (BLINK_HALF_CYCLES > 1) ? $clog2(BLINK_HALF_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(BLINK_HALF_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Reset and strap capture
  wire rst_any = sys_rst | ~external_reset_n;
  logic strap_r;
  logic in_rst_r;

  // Strap tracks the pin during reset and freezes at release
  always_ff @(posedge core_clk) begin
    in_rst_r <= rst_any;
    if (rst_any) begin
      strap_r <= irq_pin_function_strap;
    end
  end

  wire irq_mode = (strap_r == pls_pkg::STRAP_IRQ);

  //////////////////////////////////////////////////////////////////////////////
  // Activity blink
  pls_pkg::pls_blink_e state_r, state_nxt;
  logic [CW-1:0] cnt_r;
  logic pend_r;
  wire cnt_done = (cnt_r == CNT_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pls_pkg::PLS_IDLE: if (link_up && (activity || pend_r)) state_nxt = pls_pkg::PLS_OFF;
      pls_pkg::PLS_OFF: if (cnt_done) state_nxt = pls_pkg::PLS_ON;
      pls_pkg::PLS_ON: if (cnt_done) state_nxt = pls_pkg::PLS_IDLE;
      // Fourth code of the two-bit state is illegal; recover to idle
      default: state_nxt = pls_pkg::PLS_IDLE;
    endcase
    if (!link_up) state_nxt = pls_pkg::PLS_IDLE;
  end

  wire link_activity_led_nxt = (link_up && state_nxt != pls_pkg::PLS_OFF) ? pls_pkg::LED_ON
                : pls_pkg::LED_OFF;
  wire speed_led_nxt = (speed_100 && !line_isolate) ? pls_pkg::LED_ON
                : pls_pkg::LED_OFF;

  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      state_r <= pls_pkg::PLS_IDLE;
      cnt_r <= '0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= (state_nxt != state_r || cnt_done) ? '0 : cnt_r + 1'b1;
      // Activity during a blink is remembered so a busy link keeps blinking
      if (state_r == pls_pkg::PLS_IDLE || !link_up) begin
        pend_r <= 1'b0;
      end else if (activity) begin
        pend_r <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive, all registered
  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      link_activity_led <= pls_pkg::LED_OFF;
      speed_led <= pls_pkg::LED_OFF;
      interrupt_out_n <= pls_pkg::IRQ_IDLE_N;
      shared_pin_oe <= 1'b0;
      transmit_error_in <= 1'b0;
      transmit_symbol_bit4 <= 1'b0;
      mdc_core <= 1'b0;
      mdio_core_in <= 1'b1;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
    end else begin
      link_activity_led <= link_activity_led_nxt;
      speed_led <= speed_led_nxt;
      interrupt_out_n <= irq_mode ? ~irq_request : pls_pkg::IRQ_IDLE_N;
      shared_pin_oe <= irq_mode;
      transmit_error_in <= irq_mode ? 1'b0 : shared_pin_in;
      transmit_symbol_bit4 <= irq_mode ? 1'b0 : shared_pin_in;
      mdc_core <= mdc;
      mdio_core_in <= mdio_in;
      mdio_out <= mdio_out_val;
      mdio_oe <= mdio_drive;
    end
  end

  always_ff @(posedge core_clk) begin
    soft_reset_req <= in_rst_r;
  end
endmodule : pls_top

// ==== hdl/pls_pkg.sv ====
/*
  Constants shared by the status indicator and strap select block.
  Assumes a single 100 MHz core clock and synchronous active-high reset.
*/
// Overview of operation
// - Straps captured at power-on and each system reset, held until next reset.
// - Link activity indicator goes active whenever a valid link is present.
// - While link is up, activity makes the link activity indicator blink.
// - Speed indicator active while resolved speed is 100 Mbps.
// - Speed indicator inactive at 10 Mbps and during line isolation.
// - Strap floating or high selects shared pin as active-low interrupt output.
// - Strap low selects shared pin as transmit error / symbol bit 4 input.
// - Low level on external reset input requests a system reset.
// - Management data is bidirectional; management clock is always an input.
package pls_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Blink half period in ms
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  localparam logic LED_ON = 1'b1;
  localparam logic LED_OFF = 1'b0;
  localparam logic STRAP_IRQ = 1'b1;
  localparam logic IRQ_IDLE_N = 1'b1;
  typedef enum logic [1:0] {PLS_IDLE, PLS_ON, PLS_OFF} pls_blink_e;
endpackage : pls_pkg

// ==== tb/pls_board.sv ====
/* Board strap resistor model; assumes the bench picks the fit. */
`timescale 1ns/1ps
module pls_board (input wire logic pull_low, output logic strap);
  assign strap = pull_low ? 1'b0 : 1'b1;
endmodule : pls_board

// ==== tb/pls_top_chk.sv ====
/* Checker for pls_top ports; assumes one clock and a bind. */
`timescale 1ns/1ps
module pls_top_chk (
  input wire logic core_clk, sys_rst, external_reset_n, irq_pin_function_strap, link_up,
  input wire logic speed_100, line_isolate, irq_request, shared_pin_in, mdc, mdc_core,
  input wire logic link_activity_led, speed_led, interrupt_out_n, shared_pin_oe,
  input wire logic transmit_error_in, transmit_symbol_bit4);
  wire rst = sys_rst | ~external_reset_n;
  logic sq_r = 1'b1;
  always_ff @(posedge core_clk) if (rst) sq_r <= irq_pin_function_strap;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_SPD: assert property (!$past(rst) |->
    speed_led == $past(speed_100 & ~line_isolate)) else $error("spd");
  AST_NOL: assert property (!$past(rst) && !$past(link_up) |->
    !link_activity_led) else $error("nol");
  AST_IRQ: assert property (!$past(rst) && sq_r |->
    interrupt_out_n == !$past(irq_request)) else $error("irq");
  AST_OE: assert property ($past(rst) || shared_pin_oe == sq_r) else $error("oe");
  AST_TXE: assert property (!$past(rst) && !sq_r |->
    transmit_error_in == $past(shared_pin_in) && interrupt_out_n) else $error("txe");
  AST_TX4: assert property (!$past(rst) && !sq_r |->
    transmit_symbol_bit4 == $past(shared_pin_in)) else $error("tx4");
  AST_RST: assert property (disable iff (1'b0) $fell(rst) |->
    !speed_led && !link_activity_led && interrupt_out_n) else $error("rst");
  AST_MDC: assert property (!$past(rst) |-> mdc_core == $past(mdc)) else $error("mdc");
endmodule : pls_top_chk
bind pls_top pls_top_chk u_pls_top_chk (.*);

// ==== tb/testbench.sv ====
/* Scenario bench for pls_top; assumes the board model and bound checker. */
`timescale 1ns/1ps
module testbench;
  logic c = 0, r = 1, n = 1, p = 0, lu = 0, a = 0, sp = 0, iso = 0, q = 0, si = 0;
  logic st, la, sl, io, oe, te, tx4, mci, mo, moe, srr;
  int bad_count = 0, num_checks = 0;
  initial forever #5 c = ~c;
  pls_board u_pls_board (.pull_low(p), .strap(st));
  pls_top #(.BLINK_HALF_CYCLES(4)) u_pls_top (.core_clk(c), .sys_rst(r), .external_reset_n(n),
    .irq_pin_function_strap(st), .link_up(lu), .activity(a), .speed_100(sp), .line_isolate(iso),
    .irq_request(q), .shared_pin_in(si), .mdc(a), .mdio_in(lu), .mdio_drive(sp), .mdio_out_val(q),
    .link_activity_led(la), .speed_led(sl), .interrupt_out_n(io), .shared_pin_oe(oe),
    .transmit_error_in(te), .transmit_symbol_bit4(tx4), .mdc_core(), .mdio_core_in(mci),
    .mdio_out(mo), .mdio_oe(moe), .soft_reset_req(srr));
  task automatic k(string s, logic g, logic e);
    num_checks++;
    if (g !== e) begin bad_count++; $display("BAD %s exp %b got %b", s, e, g); end
  endtask : k
  task automatic w(int i); repeat (i) @(posedge c); #1; endtask : w
  task automatic t_led;
    @(posedge c) lu <= 1; w(2); k("la", la, 1);
    @(posedge c) a <= 1; @(posedge c) a <= 0; #1 k("la", la, 0);
    w(5); k("la", la, 1);
    @(posedge c) lu <= 0; w(2); k("la", la, 0);
    $display("led end");
  endtask : t_led
  task automatic t_spd;
    for (int i = 0; i < 4; i++) begin
      @(posedge c) {sp, iso} <= i[1:0]; w(2); k("sl", sl, i[1] & !i[0]);
    end
    $display("spd end");
  endtask : t_spd
  // Strap flips at release: must be ignored
  task automatic t_pin(logic v, logic s);
    @(posedge c) {p, r, n, q, si} <= {!v, s, s, 2'b11};
    w(3); k("srr", srr, 1); k("moe", moe, 0); k("mo", mo, 1);
    @(posedge c) {r, n, p} <= {1'b0, 1'b1, v};
    w(3); k("io", io, !v); k("oe", oe, v); k("te", te, !v);
    k("tx4", tx4, !v);
    k("srr", srr, 0); k("moe", moe, sp); k("mo", mo, q); k("mci", mci, lu);
    $display("pin end");
  endtask : t_pin
  task automatic wrap_up;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge c); r <= 0;
    t_led; t_spd; t_pin(0, 1); t_pin(1, 0); t_pin(0, 0); wrap_up;
  end
  initial begin #9000; bad_count++; wrap_up; end
endmodule : testbench
